// ===== rtl/tmrc_pkg.sv
// Constants for the lane control of a four-lane retimer/redriver
package tmrc_pkg;
    localparam int          AXI_AW          = 8;
    localparam int          IDX_W           = 6;
    // Register indices; byte address is four times the index
    localparam logic [5:0]  IDX_PWR         = 6'h09;
    localparam logic [5:0]  IDX_CTRL        = 6'h0A;
    localparam logic [5:0]  IDX_EQ          = 6'h0D;
    localparam logic [5:0]  IDX_STAT        = 6'h10;
    localparam int          PWR_SWAP_BIT    = 7;
    localparam int          PWR_PD_BIT      = 3;
    localparam int          CTRL_RATIO_BIT  = 0;
    localparam int          CTRL_SIGDET_BIT = 1;
    localparam int          CTRL_DDC_BIT    = 2;
    localparam int          CTRL_MODE_LSB   = 3;
    localparam int          CTRL_EQREG_BIT  = 5;
    localparam logic [7:0]  PWR_RST         = 8'h00;
    localparam logic [7:0]  CTRL_RST        = 8'h00;
    localparam logic [7:0]  EQ_RST          = 8'hAA;
    localparam logic [1:0]  MODE_AUTO       = 2'h0;
    localparam logic [1:0]  MODE_RETIMER    = 2'h1;
    localparam logic [1:0]  MODE_REDRIVER   = 2'h2;
    localparam logic [1:0]  EQ_LOW          = 2'h0;
    localparam logic [1:0]  EQ_HIGH         = 2'h1;
    localparam logic [1:0]  EQ_ADAPT        = 2'h2;
    localparam logic [1:0]  STRAP_LOW       = 2'h0;
    localparam logic [1:0]  STRAP_HIGH      = 2'h1;
    localparam logic [1:0]  STRAP_FLOAT     = 2'h2;
    localparam logic [1:0]  TERM_NONE       = 2'h0;
    localparam logic [1:0]  TERM_WIDE       = 2'h1;
    localparam logic [1:0]  TERM_NARROW     = 2'h2;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          MEAS_WINDOW_NS  = 10000;
    localparam int          MEAS_WINDOW_CYC = MEAS_WINDOW_NS / CLK_PERIOD_NS;
    localparam int          BITS_PER_CLK    = 10;
    localparam int          MBPS_PER_EDGE   = BITS_PER_CLK * 1000 / MEAS_WINDOW_NS;
    localparam int          RATE_W          = 16;
    localparam logic [15:0] RATE_XOVER_MBPS = 16'h03E8;
    localparam logic [15:0] RATE_TERM_MBPS  = 16'h07D0;
    localparam logic [15:0] RATE_REDRV_MAX  = 16'h0D48;
    localparam logic [15:0] RATE_RETIM_MAX  = 16'h1770;
    // Arbitrary upper bits of the serial bus address
    localparam logic [6:0]  BUS_ADDR_BASE   = 7'h58;
endpackage

// ===== rtl/tmrc_lane_ctrl.sv
// Lane control of a four-lane retimer/redriver with an AXI4-Lite register slave
//
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
module tmrc_lane_ctrl #(
    parameter int WIN_CYC = tmrc_pkg::MEAS_WINDOW_CYC
) (
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        link_clock,
    input  wire logic        link_enable,
    input  wire logic        hot_plug_detect,
    input  wire logic        signal_detect_enable,
    input  wire logic        swap_polarity_strap,
    input  wire logic [1:0]  equalizer_select_strap,
    input  wire logic [1:0]  termination_select_strap,
    input  wire logic [1:0]  bus_address_straps,
    input  wire logic        serial_config_enable,
    output logic             lane_output_enable,
    output logic             power_down,
    output logic             rx_power_on,
    output logic             retimer_mode,
    output logic             rate_over_limit,
    output logic             clock_div40,
    output logic             ddc_pass_enable,
    output logic             ddc_rate_400k,
    output logic [6:0]       bus_address,
    output logic [7:0]       lane_source,
    output logic [3:0]       polarity_invert,
    output logic [7:0]       eq_gain,
    output logic [1:0]       termination
);
    typedef enum logic [1:0] {
        TMRC_W_IDLE = 2'b01,
        TMRC_W_RESP = 2'b10
    } tmrc_wst_t;

    typedef struct packed {
        logic        le_s1, le_s2, hpd_s1, hpd_s2, lclk_s1, lclk_s2;
        logic        sd_s1, sd_s2, sw_s1, sw_s2, cfg_s1, cfg_s2;
        logic [1:0]  eq_s1, eq_s2, term_s1, term_s2, adr_s1, adr_s2;
        logic        lclk_prev, le_prev, hpd_prev, init_done;
        logic [1:0]  eq_strap, term_strap, adr_strap;
        logic        sw_strap, sd_strap, cfg_strap;
        logic [7:0]  pwr, ctrl, eq;
        logic [15:0] win_cnt;
        logic [11:0] edge_cnt, edges;
        logic        sig_valid;
        tmrc_wst_t   wst;
        logic        aw_have, w_have;
        logic [5:0]  aw_idx;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        awready, wready, bvalid, arready, rvalid;
        logic [1:0]  bresp, rresp;
        logic [31:0] rdata;
        logic        lane_oe, pd, rx_on, retim, over, div40, ddc_en, ddc_fast;
        logic [6:0]  baddr;
        logic [7:0]  src, eqo;
        logic [3:0]  pol;
        logic [1:0]  term;
    } tmrc_state_t;

    tmrc_state_t st;
    tmrc_state_t next_st;

    // Swap pairs clock with lane two and lane one with lane zero
    function automatic logic [1:0] lane_map(input logic [1:0] lane, input logic swap);
        lane_map = swap ? (lane ^ 2'h1) : lane;
    endfunction

    function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] d,
                                              input logic [3:0] strb);
        merge_byte = strb[0] ? d[7:0] : old;
    endfunction

    function automatic logic mapped(input logic [5:0] idx);
        mapped = (idx == tmrc_pkg::IDX_PWR) || (idx == tmrc_pkg::IDX_CTRL) ||
                 (idx == tmrc_pkg::IDX_EQ) || (idx == tmrc_pkg::IDX_STAT);
    endfunction

    logic [15:0] rate;
    logic [1:0]  mode;
    logic        retim;
    logic        active;
    logic        swap_en;
    logic        standby;
    logic        sd_en;
    logic [1:0]  strap_eq;
    logic [1:0]  lane_eq;
    logic [1:0]  src_lane;
    logic [5:0]  ar_idx;
    logic        wr_go;
    logic        le_rise;
    logic        hpd_rise;
    logic [31:0] stat_word;

    always_comb begin
        next_st = st;
        rate = '0;
        mode = '0;
        retim = 1'b0;
        active = 1'b0;
        swap_en = 1'b0;
        standby = 1'b0;
        sd_en = 1'b0;
        strap_eq = '0;
        lane_eq = '0;
        src_lane = '0;
        ar_idx = '0;
        wr_go = 1'b0;
        le_rise = 1'b0;
        hpd_rise = 1'b0;
        stat_word = '0;

        // Pins cross into mclk through two flops each
        next_st.le_s1 = link_enable;
        next_st.le_s2 = st.le_s1;
        next_st.hpd_s1 = hot_plug_detect;
        next_st.hpd_s2 = st.hpd_s1;
        next_st.lclk_s1 = link_clock;
        next_st.lclk_s2 = st.lclk_s1;
        next_st.sd_s1 = signal_detect_enable;
        next_st.sd_s2 = st.sd_s1;
        next_st.sw_s1 = swap_polarity_strap;
        next_st.sw_s2 = st.sw_s1;
        next_st.cfg_s1 = serial_config_enable;
        next_st.cfg_s2 = st.cfg_s1;
        next_st.eq_s1 = equalizer_select_strap;
        next_st.eq_s2 = st.eq_s1;
        next_st.term_s1 = termination_select_strap;
        next_st.term_s2 = st.term_s1;
        next_st.adr_s1 = bus_address_straps;
        next_st.adr_s2 = st.adr_s1;
        next_st.lclk_prev = st.lclk_s2;
        next_st.le_prev = st.le_s2;
        next_st.hpd_prev = st.hpd_s2;
        le_rise = st.le_s2 && !st.le_prev;
        hpd_rise = st.hpd_s2 && !st.hpd_prev;

        // Straps are caught once after reset and on each enable rise only
        next_st.init_done = 1'b1;
        if (st.le_s2 && (!st.init_done || le_rise)) begin
            next_st.eq_strap = st.eq_s2;
            next_st.term_strap = st.term_s2;
            next_st.adr_strap = st.adr_s2;
            next_st.sw_strap = st.sw_s2;
            next_st.sd_strap = st.sd_s2;
            next_st.cfg_strap = st.cfg_s2;
        end

        // Rate meter: link clock edges counted over a fixed window
        if (st.lclk_s2 && !st.lclk_prev && st.edge_cnt != 12'hFFF) begin
            next_st.edge_cnt = st.edge_cnt + 12'h001;
        end
        if (st.win_cnt >= 16'(WIN_CYC - 1)) begin
            // Edge seen in the closing cycle still belongs to this window
            next_st.win_cnt = '0;
            next_st.edges = next_st.edge_cnt;
            next_st.sig_valid = (next_st.edge_cnt != '0);
            next_st.edge_cnt = '0;
        end else begin
            next_st.win_cnt = st.win_cnt + 16'h0001;
        end
        rate = 16'(st.edges * tmrc_pkg::MBPS_PER_EDGE);
        if (st.ctrl[tmrc_pkg::CTRL_RATIO_BIT]) begin
            rate = 16'(rate * 4);
        end

        mode = st.ctrl[tmrc_pkg::CTRL_MODE_LSB +: 2];
        case (mode)
            tmrc_pkg::MODE_RETIMER:  retim = 1'b1;
            tmrc_pkg::MODE_REDRIVER: retim = 1'b0;
            default:                 retim = (rate >= tmrc_pkg::RATE_XOVER_MBPS);
        endcase

        active = st.le_s2 && st.hpd_s2 && !st.pwr[tmrc_pkg::PWR_PD_BIT];
        sd_en = st.sd_strap || st.ctrl[tmrc_pkg::CTRL_SIGDET_BIT];
        standby = sd_en && !st.sig_valid;
        swap_en = !st.sw_strap || st.pwr[tmrc_pkg::PWR_SWAP_BIT];

        case (st.eq_strap)
            tmrc_pkg::STRAP_HIGH: strap_eq = tmrc_pkg::EQ_HIGH;
            tmrc_pkg::STRAP_LOW:  strap_eq = tmrc_pkg::EQ_LOW;
            default:              strap_eq = tmrc_pkg::EQ_ADAPT;
        endcase

        for (int i = 0; i < 4; i++) begin
            src_lane = lane_map(2'(i), swap_en);
            next_st.src[2*i +: 2] = src_lane;
            // Input lane takes the setting of the output lane it now feeds
            lane_eq = st.ctrl[tmrc_pkg::CTRL_EQREG_BIT] ? st.eq[2*i +: 2] : strap_eq;
            if (lane_eq == tmrc_pkg::EQ_ADAPT && !retim) begin
                lane_eq = tmrc_pkg::EQ_HIGH;
            end
            next_st.eqo[2*src_lane +: 2] = lane_eq;
        end
        next_st.pol = (st.sw_strap && retim) ? 4'hF : 4'h0;

        case (st.term_strap)
            tmrc_pkg::STRAP_HIGH: next_st.term = tmrc_pkg::TERM_NONE;
            tmrc_pkg::STRAP_LOW:  next_st.term = tmrc_pkg::TERM_NARROW;
            default: begin
                if (rate > tmrc_pkg::RATE_REDRV_MAX) begin
                    next_st.term = tmrc_pkg::TERM_NARROW;
                end else if (rate > tmrc_pkg::RATE_TERM_MBPS) begin
                    next_st.term = tmrc_pkg::TERM_WIDE;
                end else begin
                    next_st.term = tmrc_pkg::TERM_NONE;
                end
            end
        endcase

        next_st.retim = retim;
        next_st.over = retim ? (rate > tmrc_pkg::RATE_RETIM_MAX)
                             : (rate > tmrc_pkg::RATE_REDRV_MAX);
        next_st.pd = !active;
        next_st.lane_oe = active && !standby;
        next_st.rx_on = active && !standby;
        // Stale flag must not leak out in the cycle it is being cleared
        next_st.div40 = active && st.ctrl[tmrc_pkg::CTRL_RATIO_BIT]
                        && !le_rise && !hpd_rise;
        next_st.ddc_en = active;
        next_st.ddc_fast = st.ctrl[tmrc_pkg::CTRL_DDC_BIT];
        next_st.baddr = st.cfg_strap ? {tmrc_pkg::BUS_ADDR_BASE[6:2], st.adr_strap}
                                     : 7'h00;

        stat_word = {8'h00, st.term, st.sw_strap, swap_en, st.over, standby, !active,
                     retim, rate};

        // Write channel: address and data taken in either order
        next_st.awready = 1'b0;
        next_st.wready = 1'b0;
        case (st.wst)
            TMRC_W_IDLE: begin
                if (s_axi_awvalid && st.awready) begin
                    next_st.aw_have = 1'b1;
                    next_st.aw_idx = s_axi_awaddr[7:2];
                end
                if (s_axi_wvalid && st.wready) begin
                    next_st.w_have = 1'b1;
                    next_st.wdata = s_axi_wdata;
                    next_st.wstrb = s_axi_wstrb;
                end
                next_st.awready = !next_st.aw_have && !(s_axi_awvalid && st.awready);
                next_st.wready = !next_st.w_have && !(s_axi_wvalid && st.wready);
                if (st.aw_have && st.w_have) begin
                    wr_go = 1'b1;
                    next_st.awready = 1'b0;
                    next_st.wready = 1'b0;
                    next_st.aw_have = 1'b0;
                    next_st.w_have = 1'b0;
                    next_st.bvalid = 1'b1;
                    next_st.bresp = mapped(st.aw_idx) ? tmrc_pkg::RESP_OKAY
                                                      : tmrc_pkg::RESP_SLVERR;
                    next_st.wst = TMRC_W_RESP;
                end
            end
            TMRC_W_RESP: begin
                if (s_axi_bready) begin
                    next_st.bvalid = 1'b0;
                    next_st.awready = 1'b1;
                    next_st.wready = 1'b1;
                    next_st.wst = TMRC_W_IDLE;
                end
            end
            default: begin
                next_st.wst = TMRC_W_IDLE;
                next_st.bvalid = 1'b0;
            end
        endcase

        // Resume from enable or hot plug needs a fresh ratio write; reads never clear it
        if (le_rise || hpd_rise) begin
            next_st.ctrl[tmrc_pkg::CTRL_RATIO_BIT] = 1'b0;
        end
        if (wr_go) begin
            case (st.aw_idx)
                tmrc_pkg::IDX_PWR:  next_st.pwr = merge_byte(st.pwr, st.wdata, st.wstrb);
                tmrc_pkg::IDX_CTRL: next_st.ctrl = merge_byte(st.ctrl, st.wdata, st.wstrb);
                tmrc_pkg::IDX_EQ:   next_st.eq = merge_byte(st.eq, st.wdata, st.wstrb);
                default: ;
            endcase
        end
        if (!st.le_s2) begin
            // Serial setup does not survive a disabled link
            next_st.pwr = tmrc_pkg::PWR_RST;
            next_st.ctrl = tmrc_pkg::CTRL_RST;
            next_st.eq = tmrc_pkg::EQ_RST;
        end

        // Read channel: one outstanding read, answered the cycle after address
        ar_idx = s_axi_araddr[7:2];
        if (st.rvalid) begin
            if (s_axi_rready) begin
                next_st.rvalid = 1'b0;
                next_st.arready = 1'b1;
            end
        end else if (s_axi_arvalid && st.arready) begin
            next_st.arready = 1'b0;
            next_st.rvalid = 1'b1;
            next_st.rresp = mapped(ar_idx) ? tmrc_pkg::RESP_OKAY : tmrc_pkg::RESP_SLVERR;
            case (ar_idx)
                tmrc_pkg::IDX_PWR:  next_st.rdata = {24'h000000, st.pwr};
                tmrc_pkg::IDX_CTRL: next_st.rdata = {24'h000000, st.ctrl};
                tmrc_pkg::IDX_EQ:   next_st.rdata = {24'h000000, st.eq};
                tmrc_pkg::IDX_STAT: next_st.rdata = stat_word;
                default:            next_st.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            st <= '0;
            st.wst <= TMRC_W_IDLE;
            st.pwr <= tmrc_pkg::PWR_RST;
            st.ctrl <= tmrc_pkg::CTRL_RST;
            st.eq <= tmrc_pkg::EQ_RST;
            st.eq_strap <= tmrc_pkg::STRAP_FLOAT;
            st.term_strap <= tmrc_pkg::STRAP_FLOAT;
            st.sw_strap <= 1'b1;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
            st.pd <= 1'b1;
            st.src <= 8'hE4;
            st.eqo <= tmrc_pkg::EQ_RST;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready      = st.awready;
    assign s_axi_wready       = st.wready;
    assign s_axi_bvalid       = st.bvalid;
    assign s_axi_bresp        = st.bresp;
    assign s_axi_arready      = st.arready;
    assign s_axi_rvalid       = st.rvalid;
    assign s_axi_rdata        = st.rdata;
    assign s_axi_rresp        = st.rresp;
    assign lane_output_enable = st.lane_oe;
    assign power_down         = st.pd;
    assign rx_power_on        = st.rx_on;
    assign retimer_mode       = st.retim;
    assign rate_over_limit    = st.over;
    assign clock_div40        = st.div40;
    assign ddc_pass_enable    = st.ddc_en;
    assign ddc_rate_400k      = st.ddc_fast;
    assign bus_address        = st.baddr;
    assign lane_source        = st.src;
    assign polarity_invert    = st.pol;
    assign eq_gain            = st.eqo;
    assign termination        = st.term;
endmodule

// ===== tb/tmrc_lane_monitor.sv
// Concurrent checks on the lane control ports, bound into the design
`timescale 1ns/1ns
module tmrc_lane_monitor (
    input wire logic       mclk,
    input wire logic       nrst,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    input wire logic       link_enable,
    input wire logic       hot_plug_detect,
    input wire logic       lane_output_enable,
    input wire logic       power_down,
    input wire logic       retimer_mode,
    input wire logic       clock_div40,
    input wire logic [3:0] polarity_invert
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_wr_answer;
        !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
    endsequence
    AST_WR_ANSWER: assert property (s_wr_taken |=> s_wr_answer)
        else $error("write response not two cycles after request");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data not one cycle after request");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    AST_OE_OFF: assert property (!link_enable [*5] |-> !lane_output_enable)
        else $error("lanes driven while link disabled");
    AST_PD_ENABLE: assert property (!link_enable [*5] |-> power_down)
        else $error("no power down while link disabled");
    AST_PD_HPD: assert property (!hot_plug_detect [*5] |-> power_down)
        else $error("no power down while hot plug low");
    AST_POL_RETIMER: assert property (polarity_invert != 4'h0 |-> retimer_mode)
        else $error("polarity swap outside retimer mode");
    AST_DIV40_RESUME: assert property ($rose(link_enable) |-> !clock_div40 [*6])
        else $error("divide mode kept across link enable");
    AST_DIV40_HPD: assert property ($rose(hot_plug_detect) |-> !clock_div40 [*6])
        else $error("divide mode resumed before ratio rewrite");
endmodule

bind tmrc_lane_ctrl tmrc_lane_monitor tmrc_lane_monitor_inst (
    .mclk(mclk), .nrst(nrst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .link_enable(link_enable), .hot_plug_detect(hot_plug_detect),
    .lane_output_enable(lane_output_enable), .power_down(power_down),
    .retimer_mode(retimer_mode), .clock_div40(clock_div40), .polarity_invert(polarity_invert));

// ===== tb/tmrc_source_model.sv
// Source side model: recovered link clock that stands still outside frames
`timescale 1ns/1ns
module tmrc_source_model #(
    parameter int HALF_NS = 40
) (
    input wire logic run,
    output logic     link_clock
);
    // Odd start offset keeps link clock edges off the mclk edges, 2 ns ahead of each mclk rise until run first drops
    initial begin
        link_clock = 1'b0;
        #3;
        forever begin
            if (run) begin
                #HALF_NS link_clock = ~link_clock;
            end else begin
                link_clock = 1'b0;
                wait (run);
            end
        end
    end
endmodule

// ===== tb/tb_tmrc_lane_ctrl.sv
// Self-checking bench for the lane control block
`timescale 1ns/1ns
module tb_tmrc_lane_ctrl;
    logic mclk = 1'b0, nrst = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, lk_run = 1'b1, link_en = 1'b1, hpd = 1'b1;
    logic swap_strap = 1'b1, sig_strap = 1'b0, cfg_strap = 1'b1;
    logic [1:0] eq_strap = 2'h2, term_strap = 2'h2, addr_strap = 2'h2;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, lane_source, eq_gain;
    logic [31:0] wdata = 32'h0, rdata, lfsr = 32'h14;
    logic awready, wready, bvalid, arready, rvalid, link_clock, oe, pd, rx_on, retim, div40;
    logic over, ddc_en, ddc_fast;
    logic [1:0] bresp, rresp, termination;
    logic [3:0] pol;
    logic [6:0] bus_address;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    int error_cnt = 0, n_tests = 0, k;
    localparam logic [1:0] OK = tmrc_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = tmrc_pkg::RESP_SLVERR;

    initial forever #5 mclk = ~mclk;

    tmrc_lane_ctrl #(.WIN_CYC(1000)) tmrc_lane_ctrl_inst (
        .mclk(mclk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .link_clock(link_clock), .link_enable(link_en), .hot_plug_detect(hpd),
        .signal_detect_enable(sig_strap), .swap_polarity_strap(swap_strap),
        .equalizer_select_strap(eq_strap), .termination_select_strap(term_strap),
        .bus_address_straps(addr_strap), .serial_config_enable(cfg_strap),
        .lane_output_enable(oe), .power_down(pd), .rx_power_on(rx_on), .retimer_mode(retim),
        .rate_over_limit(over), .clock_div40(div40), .ddc_pass_enable(ddc_en),
        .ddc_rate_400k(ddc_fast),
        .bus_address(bus_address), .lane_source(lane_source), .polarity_invert(pol),
        .eq_gain(eq_gain), .termination(termination));

    tmrc_source_model #(.HALF_NS(40)) tmrc_source_model_inst (.run(lk_run), .link_clock(link_clock));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task test_done;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int i;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, r});
        if (i == 50) begin
            error_cnt++;
            test_done();
        end
    endtask

    // The expected answer is queued here and compared by the read watcher
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int i;
        @(posedge mclk);
        exp_q.push_back({r, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (i == 50) begin
            error_cnt++;
            test_done();
        end
    endtask

    always @(posedge mclk) begin
        if (rvalid && rready) begin
            e = exp_q.pop_front();
            check({30'h0, rresp}, {30'h0, e[33:32]});
            check(rdata, e[31:0]);
        end
    end

    // Supply is taken as valid from time zero, so link enable may stand high
    initial begin
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        settle(2100);
        check(32'(termination), 32'(tmrc_pkg::TERM_NONE));
        check(32'(rx_on), 32'h1);
        check(32'(retim), 32'h0);
        check(32'(pd), 32'h0);
        check({ddc_en, over}, 32'h2);
        check(32'(bus_address), 32'h5A);
        check(32'(lane_source), 32'hE4);
        rd(8'h40, 32'h0020007D, OK);
        rd(8'h24, 32'h0, OK);
        rd(8'h28, 32'h0, OK);
        rd(8'h34, 32'hAA, OK);
        rd(8'h3C, 32'h0, ERR);
        wr(8'h3C, 32'h5A, ERR);
        for (k = 0; k < 3; k++) begin
            lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
            wr(8'h34, lfsr, OK);
            rd(8'h34, {24'h0, lfsr[7:0]}, OK);
        end
        wr(8'h24, 32'h80, OK);
        settle(8);
        check(32'(lane_source), 32'hB1);
        wr(8'h28, 32'h20, OK);
        wr(8'h34, 32'h14, OK);
        settle(8);
        check(32'(eq_gain), 32'h41);
        wr(8'h28, 32'h28, OK);
        settle(1100);
        check({pol, 3'h0, retim, lane_source}, 32'hF1B1);
        check(32'(over), 32'h0);
        wr(8'h28, 32'h30, OK);
        settle(1100);
        check({pol, 3'h0, retim, lane_source}, 32'h00B1);
        wr(8'h24, 32'h88, OK);
        settle(8);
        check(32'(pd), 32'h1);
        wr(8'h24, 32'h80, OK);
        settle(8);
        check(32'(pd), 32'h0);
        wr(8'h28, 32'h07, OK);
        settle(8);
        check(32'(div40), 32'h1);
        check(32'(ddc_fast), 32'h1);
        rd(8'h28, 32'h07, OK);
        rd(8'h28, 32'h07, OK);
        lk_run <= 1'b0;
        settle(2100);
        check(32'(rx_on), 32'h0);
        lk_run <= 1'b1;
        settle(2100);
        check(32'(rx_on), 32'h1);
        link_en <= 1'b0;
        term_strap <= 2'h0;
        settle(10000);
        check({pd, oe, ddc_en}, 32'h4);
        rd(8'h24, 32'h0, OK);
        link_en <= 1'b1;
        settle(10);
        rd(8'h28, 32'h0, OK);
        check(32'(div40), 32'h0);
        check(32'(termination), 32'(tmrc_pkg::TERM_NARROW));
        check(32'(lane_source), 32'hE4);
        wr(8'h28, 32'h01, OK);
        settle(8);
        check(32'(div40), 32'h1);
        hpd <= 1'b0;
        settle(8);
        check({pd, div40}, 32'h2);
        hpd <= 1'b1;
        settle(8);
        check({pd, div40}, 32'h0);
        rd(8'h28, 32'h0, OK);
        test_done();
    end
endmodule
